// ### include/flash_host_regs.svh
// timing counts and command codes for the flash bus host
// assumes a 125 MHz system clock
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
`define CLK_PERIOD_NS      8
`define T_ACCESS_NS        70
`define T_ACCESS_CYC       ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WPULSE_NS        40
`define T_WPULSE_CYC       ((`T_WPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_GLITCH_NS        5
`define T_GLITCH_CYC       ((`T_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_SETUP_CYC        1
`define UNLOCK_ADDR1       19'h00555
`define UNLOCK_ADDR2       19'h002AA
`define UNLOCK_DATA1       8'hAA
`define UNLOCK_DATA2       8'h55
`define CMD_RESET          8'hF0
`define CMD_SILICON_ID     8'h90
`define CMD_PROGRAM        8'hA0
`define CMD_ERASE_SETUP    8'h80
`define CMD_CHIP_ERASE     8'h10
`define CMD_SECTOR_ERASE   8'h30
`define CMD_SUSPEND        8'hB0
`define CMD_RESUME         8'h30
`define SECTOR_MSB         18
`define SECTOR_LSB         16
`endif

// ### include/flash_host_pkg.sv
// types shared by the flash bus host
// no assumptions beyond the header macros
package flash_host_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_SILICON_ID, OP_PROGRAM, OP_CHIP_ERASE,
    OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME
  } op_t;
  typedef enum logic [1:0] {
    MODE_ARRAY, MODE_SUSP_ARRAY, MODE_SILICON_ID, MODE_FAIL
  } readMode_t;
endpackage

// ### core/cycle_plan.sv
// per-op command sequence table: address and data of each bus cycle
// assumes op codes from flash_host_pkg, step below the op's length
`timescale 1ns/1ns
`include "flash_host_regs.svh"
module cycle_plan
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire flash_host_pkg::op_t  op,
  input  wire logic [2:0]           step,
  input  wire logic [18:0]          userAddr,
  input  wire logic [7:0]           userData,
  output logic      [18:0]          planAddr_reg,
  output logic      [7:0]           planData_reg,
  output logic      [2:0]           planLen_reg
);
  logic [18:0] planAddr_next;
  logic [7:0]  planData_next;
  logic [2:0]  planLen_next;
  logic [7:0]  thirdCmd;

  always_comb
  begin
    planAddr_next = `UNLOCK_ADDR1;
    planData_next = `UNLOCK_DATA1;
    planLen_next  = 3'h3;
    thirdCmd      = `CMD_ERASE_SETUP;
    if (op == flash_host_pkg::OP_SILICON_ID)
      thirdCmd = `CMD_SILICON_ID;
    else if (op == flash_host_pkg::OP_PROGRAM)
      thirdCmd = `CMD_PROGRAM;
    if (op == flash_host_pkg::OP_PROGRAM)
      planLen_next = 3'h4;
    else if (op == flash_host_pkg::OP_CHIP_ERASE || op == flash_host_pkg::OP_SECTOR_ERASE)
      planLen_next = 3'h6;
    else if (op == flash_host_pkg::OP_RESET || op == flash_host_pkg::OP_SUSPEND
             || op == flash_host_pkg::OP_RESUME)
      planLen_next = 3'h1;
    case (op)
      flash_host_pkg::OP_RESET:   planData_next = `CMD_RESET;
      flash_host_pkg::OP_SUSPEND: planData_next = `CMD_SUSPEND;
      flash_host_pkg::OP_RESUME:  planData_next = `CMD_RESUME;
      default:
      begin
        case (step)
          3'h0, 3'h3:
          begin
            planAddr_next = `UNLOCK_ADDR1;
            planData_next = `UNLOCK_DATA1;
          end
          3'h1, 3'h4:
          begin
            planAddr_next = `UNLOCK_ADDR2;
            planData_next = `UNLOCK_DATA2;
          end
          default:
          begin
            planAddr_next = `UNLOCK_ADDR1;
            planData_next = thirdCmd;
          end
        endcase
        if (op == flash_host_pkg::OP_PROGRAM && step == 3'h3)
        begin
          planAddr_next = userAddr;
          planData_next = userData;
        end
        if (op == flash_host_pkg::OP_CHIP_ERASE && step == 3'h5)
          planData_next = `CMD_CHIP_ERASE;
        if (op == flash_host_pkg::OP_SECTOR_ERASE && step == 3'h5)
        begin
          planAddr_next = userAddr;
          planData_next = `CMD_SECTOR_ERASE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      planAddr_reg <= 19'h00000;
      planData_reg <= 8'h00;
      planLen_reg  <= 3'h1;
    end
    else
    begin
      planAddr_reg <= planAddr_next;
      planData_reg <= planData_next;
      planLen_reg  <= planLen_next;
    end
  end
endmodule

// ### core/flash_bus_mode_control.sv
// host-side controller driving an asynchronous byte-wide flash over its pins
// assumes the flash pins are sampled synchronously and the bench resolves data_lines
`timescale 1ns/1ns
`include "flash_host_regs.svh"
// Overview of operation
// - read with chip select, output enable low
// - reset command after failure or ID mode
// - write strobe, chip select low, output high
// - host writes only defined command sequences; while hvIdReq is high, address bit one of writes is also forced low
// - ID command is three writes, then reads
module flash_bus_mode_control
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 reqValid,
  input  wire flash_host_pkg::op_t  reqOp,
  input  wire logic [18:0]          reqAddr,
  input  wire logic [7:0]           reqData,
  input  wire logic                 hvIdReq,
  input  wire logic                 opDone,
  input  wire logic [7:0]           data_lines_i,
  output logic                      reqReady_reg,
  output logic                      rspValid_reg,
  output logic      [7:0]           rspData_reg,
  output logic      [2:0]           rspSector_reg,
  output flash_host_pkg::readMode_t readMode_reg,
  output logic                      failSeen_reg,
  output logic      [18:0]          addr_reg,
  output logic      [7:0]           data_lines_o_reg,
  output logic                      data_lines_oe_b_reg,
  output logic                      chipSel_b_reg,
  output logic                      outEn_b_reg,
  output logic                      writeStrobe_b_reg,
  output logic                      high_voltage_id_pin_reg
);
  typedef enum logic [2:0] {IDLE, PLAN, SETUP, PULSE, HOLD, RDWAIT, DONE} state_t;
  localparam logic [3:0] ACC_CYC = 4'(`T_ACCESS_CYC);
  localparam logic [3:0] WP_CYC  = 4'(`T_WPULSE_CYC);

  state_t                state_reg;
  flash_host_pkg::op_t   op_reg;
  logic [18:0]           userAddr_reg;
  logic [7:0]            userData_reg;
  logic [2:0]            step_reg;
  logic [3:0]            cnt_reg;
  logic                  susp_reg;
  logic                  busy_reg;
  flash_host_pkg::readMode_t idFrom_reg;
  logic [18:0]           planAddr;
  logic [7:0]            planData;
  logic [2:0]            planLen;
  logic                  isWrite;

  assign isWrite = (op_reg != flash_host_pkg::OP_READ);

  cycle_plan planner
  (
    .clk          (clk),
    .rst_b        (rst_b),
    .op           (op_reg),
    .step         (step_reg),
    .userAddr     (userAddr_reg),
    .userData     (userData_reg),
    .planAddr_reg (planAddr),
    .planData_reg (planData),
    .planLen_reg  (planLen)
  );

  // ============================================================
  // sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= IDLE;
      op_reg <= flash_host_pkg::OP_READ;
      userAddr_reg <= 19'h00000;
      userData_reg <= 8'h00;
      step_reg <= 3'h0;
      cnt_reg <= 4'h0;
      reqReady_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        IDLE:
        begin
          reqReady_reg <= 1'b1;
          step_reg <= 3'h0;
          if (reqValid && reqReady_reg)
          begin
            reqReady_reg <= 1'b0;
            op_reg <= reqOp;
            userAddr_reg <= reqAddr;
            userData_reg <= reqData;
            state_reg <= PLAN;
          end
        end
        PLAN:
          state_reg <= SETUP;
        SETUP:
        begin
          cnt_reg <= 4'h0;
          state_reg <= PULSE;
        end
        PULSE:
        begin
          cnt_reg <= cnt_reg + 4'h1;
          // pulse well above the glitch width
          if (isWrite && cnt_reg == WP_CYC - 4'h1)
            state_reg <= HOLD;
          else if (!isWrite && cnt_reg == ACC_CYC - 4'h1)
            state_reg <= RDWAIT;
        end
        HOLD:
        begin
          // all cycles of the sequence are issued in order
          if (step_reg == planLen - 3'h1)
            state_reg <= DONE;
          else
          begin
            step_reg <= step_reg + 3'h1;
            state_reg <= PLAN;
          end
        end
        RDWAIT:
          state_reg <= DONE;
        default:
          state_reg <= IDLE;
      endcase
    end
  end

  // ============================================================
  // pins: address, strobes and data drive
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_reg <= 19'h00000;
      data_lines_o_reg <= 8'h00;
      data_lines_oe_b_reg <= 1'b1;
      chipSel_b_reg <= 1'b1;
      outEn_b_reg <= 1'b1;
      writeStrobe_b_reg <= 1'b1;
      high_voltage_id_pin_reg <= 1'b0;
    end
    else
    begin
      // high voltage follows the request unless busy; bit one is forced low in addresses set up meanwhile
      high_voltage_id_pin_reg <= hvIdReq && !busy_reg;
      if (state_reg == SETUP)
      begin
        addr_reg <= isWrite ? planAddr : userAddr_reg;
        if (hvIdReq)
          addr_reg[1] <= 1'b0;
        data_lines_o_reg <= planData;
        data_lines_oe_b_reg <= !isWrite;
      end
      else if (state_reg == PULSE)
      begin
        chipSel_b_reg <= 1'b0;
        // write cycle keeps output enable high
        // read lowers output enable, write strobe stays high
        outEn_b_reg <= isWrite;
        writeStrobe_b_reg <= !isWrite;
      end
      else
      begin
        // both strobes rise together, data still driven
        chipSel_b_reg <= 1'b1;
        outEn_b_reg <= 1'b1;
        writeStrobe_b_reg <= 1'b1;
        if (state_reg == DONE || state_reg == IDLE)
          data_lines_oe_b_reg <= 1'b1;
      end
    end
  end

  // ============================================================
  // responses
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rspValid_reg <= 1'b0;
      rspData_reg <= 8'h00;
      rspSector_reg <= 3'h0;
    end
    else
    begin
      rspValid_reg <= (state_reg == RDWAIT);
      if (state_reg == RDWAIT)
      begin
        // id_select_bit picks manufacturer or device code
        // caller sees status when reading an erasing sector
        rspData_reg <= data_lines_i;
        // sector from top three address bits
        rspSector_reg <= userAddr_reg[`SECTOR_MSB:`SECTOR_LSB];
      end
    end
  end

  // ============================================================
  // read mode tracking
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // no write can be pending at power-up since strobes idle high
      readMode_reg <= flash_host_pkg::MODE_ARRAY;
      idFrom_reg <= flash_host_pkg::MODE_ARRAY;
      susp_reg <= 1'b0;
      busy_reg <= 1'b0;
      failSeen_reg <= 1'b0;
    end
    else
    begin
      // completion brings array or suspended array back
      // suspended program ends in suspended array
      if (busy_reg && opDone)
      begin
        busy_reg <= 1'b0;
        readMode_reg <= susp_reg ? flash_host_pkg::MODE_SUSP_ARRAY
                                 : flash_host_pkg::MODE_ARRAY;
      end
      // failure flag forces a reset before array reads
      if (state_reg == RDWAIT && busy_reg && data_lines_i[5])
      begin
        failSeen_reg <= 1'b1;
        readMode_reg <= flash_host_pkg::MODE_FAIL;
      end
      // commands change the mode only at end of a complete sequence
      if (state_reg == DONE && isWrite)
      begin
        case (op_reg)
          flash_host_pkg::OP_RESET:
          begin
            // reset ignored while operation runs cleanly
            if (!busy_reg || failSeen_reg)
            begin
              failSeen_reg <= 1'b0;
              busy_reg <= 1'b0;
              // return to the mode ID was entered from
              readMode_reg <= (readMode_reg == flash_host_pkg::MODE_SILICON_ID) ? idFrom_reg
                              : flash_host_pkg::MODE_ARRAY;
              if (readMode_reg != flash_host_pkg::MODE_SILICON_ID)
                susp_reg <= 1'b0;
            end
          end
          flash_host_pkg::OP_SILICON_ID:
          begin
            // entry after three writes, reads repeat
            if (readMode_reg == flash_host_pkg::MODE_ARRAY
                || readMode_reg == flash_host_pkg::MODE_SUSP_ARRAY)
            begin
              idFrom_reg <= readMode_reg;
              readMode_reg <= flash_host_pkg::MODE_SILICON_ID;
            end
          end
          flash_host_pkg::OP_SUSPEND:
          begin
            susp_reg <= 1'b1;
            busy_reg <= 1'b0;
            readMode_reg <= flash_host_pkg::MODE_SUSP_ARRAY;
          end
          flash_host_pkg::OP_RESUME:
          begin
            susp_reg <= 1'b0;
            busy_reg <= 1'b1;
          end
          default:
            // only table sequences reach the pins
            busy_reg <= 1'b1;
        endcase
      end
    end
  end

  // ============================================================
  // checks
  property readStrobes;
    @(posedge clk) disable iff (!rst_b)
      !outEn_b_reg |-> !chipSel_b_reg && writeStrobe_b_reg;
  endproperty
  read_strobes_a: assert property (readStrobes) else $error("bad read strobes");
  write_oe_high_a: assert property (@(posedge clk) disable iff (!rst_b)
      !writeStrobe_b_reg |-> outEn_b_reg && !data_lines_oe_b_reg)
    else $error("write with output enabled");
  sequence wrFall;
    $fell(writeStrobe_b_reg);
  endsequence
  write_pulse_width_a: assert property (@(posedge clk) disable iff (!rst_b)
      wrFall |-> !writeStrobe_b_reg [*5])
    else $error("write pulse too short");
  data_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(writeStrobe_b_reg) |-> !data_lines_oe_b_reg)
    else $error("data released before strobe");
  reset_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> readMode_reg == flash_host_pkg::MODE_ARRAY)
    else $error("not in array after reset");
  hv_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
      high_voltage_id_pin_reg && !outEn_b_reg |-> !addr_reg[1])
    else $error("address bit one high in id mode");
  sector_a: assert property (@(posedge clk) disable iff (!rst_b)
      rspValid_reg |-> rspSector_reg == $past(userAddr_reg[18:16]))
    else $error("sector mismatch");
  fail_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
      failSeen_reg |-> readMode_reg == flash_host_pkg::MODE_FAIL
                       || $past(op_reg) != flash_host_pkg::OP_RESET)
    else $error("fail flag without fail mode");
endmodule

// ### testbench/flash_device_model.sv
// behavioural flash device on the far side of the bus host
// assumes strobes and address come from the host pins, data bus resolved by the bench
`timescale 1ns/1ns
`include "flash_host_regs.svh"
module flash_device_model
#(
  parameter logic [7:0] MFR_CODE  = 8'h3E, // arbitrary
  parameter logic [7:0] DEV_CODE  = 8'h71, // arbitrary
  parameter logic [7:0] STATUS    = 8'h80,
  parameter int         PROG_CYC  = 20,
  parameter int         ERASE_CYC = 300,
  parameter logic [18:0] FAIL_ADDR = 19'h77777
)
(
  input  wire logic        clk,
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  dataIn,
  input  wire logic        chipSel_b,
  input  wire logic        outEn_b,
  input  wire logic        writeStrobe_b,
  input  wire logic        hvPin,
  output logic      [7:0]  dataOut,
  output logic             drive,
  output logic             opDone
);
  logic [18:0] latAddr;
  logic [18:0] progAddr;
  logic [7:0]  progData;
  logic [2:0]  eraseSector;
  logic [1:0]  seq;
  logic        arm;
  logic        idMode;
  logic        susp;
  logic        erasing;
  logic        progBusy;
  logic        progValid;
  logic        failed;
  logic        skipFirst;
  int          progLeft;
  int          eraseLeft;
  time         fallTime;
  // valid write needs both strobes low, output high
  wire wrAct = !chipSel_b && !writeStrobe_b && outEn_b;

  initial
  begin
    {seq, arm, idMode, susp, erasing, progBusy, progValid, opDone, failed} = '0;
    // strobes low at power-up swallow the first write
    #1 skipFirst = wrAct;
  end

  // ==========================================
  // command capture
  // address at the later falling strobe
  always @(posedge wrAct)
  begin
    latAddr = addr;
    fallTime = $time;
  end

  // data at the earlier rise, short pulses dropped
  always @(negedge wrAct)
  begin
    if (skipFirst)
      skipFirst = 1'b0;
    else if ($time - fallTime >= `T_GLITCH_NS)
      command(latAddr, dataIn);
  end

  task automatic command(input logic [18:0] a, input logic [7:0] d);
    if (erasing && !susp)
      susp = (d == `CMD_SUSPEND);
    else if (progBusy && !(failed && d == `CMD_RESET))
      seq = seq;
    else if (d == `CMD_RESET)
      {idMode, seq, arm, failed, progBusy} = '0;
    else if (susp && seq == 0 && d == `CMD_RESUME)
      susp = 1'b0;
    else if (seq == 0 && a == `UNLOCK_ADDR1 && d == `UNLOCK_DATA1)
      seq = 1;
    else if (seq == 1 && a == `UNLOCK_ADDR2 && d == `UNLOCK_DATA2)
      seq = 2;
    else if (seq == 2 && d == `CMD_SILICON_ID)
      {idMode, seq} = {1'b1, 2'd0};
    else if (seq == 2 && d == `CMD_PROGRAM)
      seq = 3;
    else if (seq == 2 && d == `CMD_ERASE_SETUP)
      {arm, seq} = {1'b1, 2'd0};
    else if (seq == 2 && arm && d == `CMD_SECTOR_ERASE)
    begin
      // sector is the top three address bits
      eraseSector = a[`SECTOR_MSB:`SECTOR_LSB];
      {erasing, arm, seq} = {1'b1, 1'b0, 2'd0};
      eraseLeft = ERASE_CYC;
    end
    else if (seq == 3)
    begin
      {progAddr, progData, progValid, progBusy} = {a, d, 2'b11};
      failed = (a == FAIL_ADDR);
      progLeft = PROG_CYC;
      seq = 0;
    end
    else
      seq = 0;
  endtask

  // ==========================================
  // embedded operation timing
  // completion returns to read array
  always @(posedge clk)
  begin
    opDone <= 1'b0;
    if (progBusy && !failed)
      progLeft <= progLeft - 1;
    if (progBusy && !failed && progLeft == 1)
      {progBusy, opDone} <= 2'b01;
    if (erasing && !susp)
      eraseLeft <= eraseLeft - 1;
    if (erasing && !susp && eraseLeft == 1)
      {erasing, opDone} <= 2'b01;
  end

  // ==========================================
  // read path
  // output only with chip select and output enable low
  assign drive = !chipSel_b && !outEn_b;
  // id codes, status for busy or erasing sector
  always_comb
  begin
    if (idMode || (hvPin && !addr[1]))
      dataOut = addr[0] ? DEV_CODE : MFR_CODE;
    else if (progBusy || (erasing && (!susp || addr[18:16] == eraseSector)))
      // failed program holds op_failure_flag until reset
      dataOut = failed ? (STATUS | 8'h20) : STATUS;
    else if (progValid && addr == progAddr)
      dataOut = progData;
    else
      dataOut = addr[7:0] ^ 8'h3C;
  end
endmodule

// ### testbench/flash_bus_mode_control_tb_top.sv
// self-checking bench for the flash bus host
// assumes the device model above; one request at a time
`timescale 1ns/1ns
module flash_bus_mode_control_tb_top;
  localparam logic [7:0] MFR  = 8'h3E; // arbitrary
  localparam logic [7:0] DEV  = 8'h71; // arbitrary
  localparam logic [7:0] STAT = 8'h80;
  localparam logic [18:0] FAIL_A = 19'h77777;
  logic                      clk;
  logic                      rst_b;
  logic                      reqValid;
  logic                      hvIdReq;
  flash_host_pkg::op_t       reqOp;
  flash_host_pkg::readMode_t mode;
  logic [18:0]               reqAddr;
  logic [18:0]               addr;
  logic [7:0]                reqData;
  logic [7:0]                junk;
  logic [7:0]                rspData;
  logic [7:0]                hostOut;
  logic [7:0]                devOut;
  logic [2:0]                rspSector;
  logic                      ready;
  logic                      rspValid;
  logic                      hostOe_b;
  logic                      ce_b;
  logic                      oe_b;
  logic                      we_b;
  logic                      hv;
  logic                      drive;
  logic                      opDone;
  wire  [7:0]                bus = drive ? devOut : (!hostOe_b ? hostOut : junk);
  int                        errTotal;
  int                        checked;
  int                        cycles;

  flash_bus_mode_control i_dut (.clk(clk), .rst_b(rst_b), .reqValid(reqValid),
    .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData), .hvIdReq(hvIdReq),
    .opDone(opDone), .data_lines_i(bus), .reqReady_reg(ready), .rspValid_reg(rspValid),
    .rspData_reg(rspData), .rspSector_reg(rspSector), .readMode_reg(mode),
    .failSeen_reg(), .addr_reg(addr), .data_lines_o_reg(hostOut),
    .data_lines_oe_b_reg(hostOe_b), .chipSel_b_reg(ce_b), .outEn_b_reg(oe_b),
    .writeStrobe_b_reg(we_b), .high_voltage_id_pin_reg(hv));

  flash_device_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .STATUS(STAT),
    .FAIL_ADDR(FAIL_A)) i_model (
    .clk(clk), .addr(addr), .dataIn(bus), .chipSel_b(ce_b), .outEn_b(oe_b),
    .writeStrobe_b(we_b), .hvPin(hv), .dataOut(devOut), .drive(drive), .opDone(opDone));

  // ==========================================
  // clock, released-bus pattern, hang guard
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    junk <= junk + 8'h5B;
    cycles++;
    if (cycles == 20000)
    begin
      errTotal++;
      printVerdict();
    end
  end

  // ==========================================
  // shared tasks
  task automatic printVerdict;
    if (errTotal == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [18:0] got, input logic [18:0] exp);
    checked++;
    if (got !== exp)
    begin
      errTotal++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until an edge sees ready high
  task automatic issue(input flash_host_pkg::op_t op, input logic [18:0] a, input logic [7:0] d);
    @(negedge clk);
    reqOp = op;
    {reqValid, reqAddr, reqData} = {1'b1, a, d};
    while (ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    while (op == flash_host_pkg::OP_READ && rspValid !== 1'b1)
      @(negedge clk);
    while (ready !== 1'b1)
      @(negedge clk);
  endtask

  task automatic readChk(input string what, input logic [18:0] a, input logic [7:0] exp);
    issue(flash_host_pkg::OP_READ, a, 8'h00);
    chk(what, rspData, exp);
    chk("sector", rspSector, a[18:16]);
  endtask

  // opDone is registered into the mode one edge later
  task automatic waitDone;
    while (opDone !== 1'b1)
      @(negedge clk);
    repeat (2) @(negedge clk);
  endtask

  // ==========================================
  // scenarios
  task automatic scenResetRead;
    chk("mode after reset", mode, flash_host_pkg::MODE_ARRAY);
    readChk("array read", 19'h1_2345, 8'h45 ^ 8'h3C);
    for (int s = 0; s < 8; s++)
      readChk("sector walk", {s[2:0], 16'hFFA7}, 8'hA7 ^ 8'h3C);
  endtask

  task automatic scenId;
    issue(flash_host_pkg::OP_SILICON_ID, 19'h0, 8'h00);
    chk("id mode", mode, flash_host_pkg::MODE_SILICON_ID);
    for (int k = 0; k < 4; k++)
      readChk("id code", {16'h3A00, 2'b00, k[0]}, k[0] ? DEV : MFR);
    issue(flash_host_pkg::OP_RESET, 19'h0, 8'h00);
    chk("id exit", mode, flash_host_pkg::MODE_ARRAY);
    readChk("array after id", 19'h0_0001, 8'h01 ^ 8'h3C);
  endtask

  task automatic scenProgram;
    issue(flash_host_pkg::OP_PROGRAM, 19'h2_0010, 8'hA5);
    waitDone();
    chk("mode after program", mode, flash_host_pkg::MODE_ARRAY);
    readChk("programmed", 19'h2_0010, 8'hA5);
    readChk("neighbour", 19'h7_0011, 8'h11 ^ 8'h3C);
  endtask

  task automatic scenSuspend;
    issue(flash_host_pkg::OP_SECTOR_ERASE, 19'h3_0000, 8'h00);
    issue(flash_host_pkg::OP_SUSPEND, 19'h0, 8'h00);
    chk("suspend mode", mode, flash_host_pkg::MODE_SUSP_ARRAY);
    readChk("erasing sector", 19'h3_0042, STAT);
    readChk("other sector", 19'h5_0042, 8'h42 ^ 8'h3C);
    issue(flash_host_pkg::OP_SILICON_ID, 19'h0, 8'h00);
    readChk("id in suspend", 19'h0_0001, DEV);
    issue(flash_host_pkg::OP_RESET, 19'h0, 8'h00);
    chk("back to suspend", mode, flash_host_pkg::MODE_SUSP_ARRAY);
    issue(flash_host_pkg::OP_PROGRAM, 19'h6_0007, 8'h3C);
    waitDone();
    chk("suspend kept", mode, flash_host_pkg::MODE_SUSP_ARRAY);
    readChk("program in suspend", 19'h6_0007, 8'h3C);
    readChk("still erasing", 19'h3_0001, STAT);
    issue(flash_host_pkg::OP_RESUME, 19'h0, 8'h00);
    waitDone();
    chk("erase finished", mode, flash_host_pkg::MODE_ARRAY);
    readChk("after erase", 19'h4_0003, 8'h03 ^ 8'h3C);
  endtask

  task automatic scenHighVoltage;
    @(negedge clk);
    hvIdReq = 1'b1;
    repeat (2) @(negedge clk);
    chk("hv pin", hv, 1'b1);
    readChk("hv maker", 19'h0_0000, MFR);
    readChk("hv device", 19'h0_0001, DEV);
    hvIdReq = 1'b0;
    repeat (2) @(negedge clk);
    chk("hv off", hv, 1'b0);
    readChk("hv left", 19'h0_0001, 8'h01 ^ 8'h3C);
  endtask

  task automatic scenFail;
    issue(flash_host_pkg::OP_PROGRAM, FAIL_A, 8'h00);
    readChk("failed status", 19'h0_0005, STAT | 8'h20);
    chk("fail mode", mode, flash_host_pkg::MODE_FAIL);
    issue(flash_host_pkg::OP_RESET, 19'h0, 8'h00);
    chk("fail cleared", mode, flash_host_pkg::MODE_ARRAY);
    readChk("array after fail", 19'h0_0005, 8'h05 ^ 8'h3C);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    {clk, rst_b, reqValid, hvIdReq, reqAddr, reqData, junk} = '0;
    reqOp = flash_host_pkg::OP_READ;
    {errTotal, checked, cycles} = '0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    scenResetRead();
    scenId();
    scenProgram();
    scenSuspend();
    scenHighVoltage();
    scenFail();
    printVerdict();
  end
endmodule
